// ==== rtl/srbs_slice.sv ====
// srbs_slice: executes shift-right word and the three byte-store forms.
// assumes the core supplies register operands with each issued instruction
// and applies the register and condition writebacks that this slice emits;
// the data memory port answers each byte request with mem_ready.
//
// Functional notes
// RULE_01: shift-right word is primary 31, extended 536
// RULE_02: rotate source left by 32 minus N
// RULE_03: bit 26 clear: N zeros then ones
// RULE_04: bit 26 set: all-zero mask, result zero
// RULE_05: target gets rotated word AND mask
// RULE_06: exception reg untouched; record flag updates condition
// RULE_07: store byte is primary 38, 16-bit offset
// RULE_08: low source byte written at effective address
// RULE_09: base plus sign-extended offset; base zero uses offset
// RULE_10: byte stores change no condition or exception
// RULE_11: store byte update is primary 39
// RULE_12: update base only if nonzero and no fault
// RULE_13: indexed update is primary 31, extended 247
// RULE_14: base plus index; base zero uses index
// RULE_15: record compares signed result, copies summary overflow
// RULE_16: byte request held; update waits for clean accept
`timescale 1ns/1ns

module srbs_slice (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic [31:0] source_gpr,
  input  wire logic [31:0] base_gpr_val,
  input  wire logic [31:0] index_gpr,
  input  wire logic        so_in,
  input  wire logic        mem_ready,
  input  wire logic        mem_fault,
  output logic             issue_ready,
  output logic             gpr_we,
  output logic [4:0]       gpr_idx,
  output logic [31:0]      gpr_data,
  output logic             cr0_we,
  output logic [3:0]       condition_field_zero,
  output logic             mem_valid,
  output logic [31:0]      mem_addr,
  output logic [7:0]       mem_data,
  output logic             op_done,
  output logic             op_illegal
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    srbs_pkg::srbs_state_t st;
    logic                  ready;
    logic                  gpr_we;
    logic [4:0]            gpr_idx;
    logic [31:0]           gpr_data;
    logic                  cr0_we;
    logic [3:0]            cr0;
    logic                  mem_valid;
    logic [31:0]           mem_addr;
    logic [7:0]            mem_data;
    logic                  upd;
    logic [4:0]            upd_idx;
    logic                  done;
    logic                  illegal;
  } srbs_regs_t;

  srbs_regs_t r;
  srbs_regs_t next_r;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [5:0]  primary;
  logic [9:0]  extended;
  logic [4:0]  base_idx;
  logic        record_flag;
  logic        is_shift;
  logic        is_stb;
  logic        is_stbu;
  logic        is_stbux;
  logic [4:0]  shift_n;
  logic [31:0] rotated;
  logic [31:0] shift_mask;
  logic [31:0] shift_res;
  logic [31:0] offset_ext;
  logic [31:0] base_term;
  logic [31:0] eff_addr;
  logic [3:0]  record_val;

  // field extraction and opcode match
  assign primary     = issue_instr[srbs_pkg::PRIMARY_LSB +: 6];
  assign extended    = issue_instr[srbs_pkg::EXTENDED_LSB +: 10];
  assign base_idx    = issue_instr[srbs_pkg::BASE_LSB +: 5];
  assign record_flag = issue_instr[srbs_pkg::RECORD_BIT];
  assign is_shift    = (primary == srbs_pkg::OP_EXTENDED) &&
                       (extended == srbs_pkg::XO_SHIFT_RIGHT); // RULE_01
  assign is_stb      = (primary == srbs_pkg::OP_STORE_BYTE); // RULE_07
  assign is_stbu     = (primary == srbs_pkg::OP_STORE_BYTE_U); // RULE_11
  assign is_stbux    = (primary == srbs_pkg::OP_EXTENDED) &&
                       (extended == srbs_pkg::XO_STORE_BYTE_UX); // RULE_13

  // rotate left by 32-N equals rotate right by N
  assign shift_n = index_gpr[srbs_pkg::SHIFT_CNT_LSB +: srbs_pkg::SHIFT_CNT_W];
  assign rotated = (source_gpr >> shift_n) |
                   (source_gpr << (6'd32 - {1'b0, shift_n})); // RULE_02
  // mask: N leading zeros, or all zeros when bit 26 set
  assign shift_mask = index_gpr[srbs_pkg::SHIFT_ZERO_BIT] ? // RULE_04
                      srbs_pkg::WORD_RST :
                      (32'hFFFF_FFFF >> shift_n); // RULE_03
  assign shift_res  = rotated & shift_mask; // RULE_05

  // signed compare against zero plus summary overflow copy
  assign record_val = {shift_res[31],
                       ~shift_res[31] && (shift_res != 32'h0000_0000),
                       shift_res == 32'h0000_0000,
                       so_in}; // RULE_15

  // effective address; base register 0 contributes zero
  assign offset_ext = {{16{issue_instr[srbs_pkg::OFFSET_LSB +
                                       srbs_pkg::OFFSET_W - 1]}},
                       issue_instr[srbs_pkg::OFFSET_LSB +: 16]}; // RULE_09
  assign base_term  = (base_idx == srbs_pkg::GPR_ZERO) ?
                      srbs_pkg::WORD_RST : base_gpr_val;
  assign eff_addr   = base_term + (is_stbux ? index_gpr
                                            : offset_ext); // RULE_09 RULE_14

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_r         = r;
    next_r.gpr_we  = 1'b0;
    next_r.cr0_we  = 1'b0;
    next_r.done    = 1'b0;
    next_r.illegal = 1'b0;
    case (r.st)
      srbs_pkg::SRBS_IDLE: begin
        if (issue_valid) begin
          if (is_shift) begin
            next_r.gpr_we   = 1'b1;
            next_r.gpr_idx  = base_idx; // RULE_05
            next_r.gpr_data = shift_res;
            next_r.done     = 1'b1;
            if (record_flag) begin
              next_r.cr0_we = 1'b1; // RULE_06
              next_r.cr0    = record_val;
            end
          end else if (is_stb || is_stbu || is_stbux) begin
            next_r.st        = srbs_pkg::SRBS_STORE;
            next_r.ready     = 1'b0;
            next_r.mem_valid = 1'b1; // RULE_16
            next_r.mem_addr  = eff_addr;
            next_r.mem_data  =
              source_gpr[srbs_pkg::STORE_BYTE_LSB +: 8]; // RULE_08
            next_r.upd       = (is_stbu || is_stbux) &&
                               (base_idx != srbs_pkg::GPR_ZERO);
            next_r.upd_idx   = base_idx;
          end else begin
            next_r.illegal = 1'b1;
          end
        end
      end
      srbs_pkg::SRBS_STORE: begin
        // request stands until accepted; no condition write here // RULE_10
        if (mem_ready) begin
          next_r.st        = srbs_pkg::SRBS_IDLE;
          next_r.ready     = 1'b1;
          next_r.mem_valid = 1'b0;
          next_r.done      = 1'b1;
          if (r.upd && !mem_fault) begin
            next_r.gpr_we   = 1'b1; // RULE_12
            next_r.gpr_idx  = r.upd_idx;
            next_r.gpr_data = r.mem_addr;
          end
          next_r.upd = 1'b0;
        end
      end
      default: begin
        next_r.st    = srbs_pkg::SRBS_IDLE;
        next_r.ready = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register, frozen while ce is low except that sys_rst still clears it
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r.st        <= srbs_pkg::SRBS_IDLE;
      r.ready     <= 1'b1;
      r.gpr_we    <= 1'b0;
      r.gpr_idx   <= srbs_pkg::GPR_ZERO;
      r.gpr_data  <= srbs_pkg::WORD_RST;
      r.cr0_we    <= 1'b0;
      r.cr0       <= srbs_pkg::CR_RST;
      r.mem_valid <= 1'b0;
      r.mem_addr  <= srbs_pkg::WORD_RST;
      r.mem_data  <= srbs_pkg::BYTE_RST;
      r.upd       <= 1'b0;
      r.upd_idx   <= srbs_pkg::GPR_ZERO;
      r.done      <= 1'b0;
      r.illegal   <= 1'b0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // outputs straight from the state record
  assign issue_ready          = r.ready;
  assign gpr_we               = r.gpr_we;
  assign gpr_idx              = r.gpr_idx;
  assign gpr_data             = r.gpr_data;
  assign cr0_we               = r.cr0_we;
  assign condition_field_zero = r.cr0;
  assign mem_valid            = r.mem_valid;
  assign mem_addr             = r.mem_addr;
  assign mem_data             = r.mem_data;
  assign op_done              = r.done;
  assign op_illegal           = r.illegal;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  shift_result_a: assert property ( // RULE_05
    ce && issue_ready && issue_valid && is_shift |=>
      gpr_we && gpr_data == $past(shift_res) &&
      gpr_idx == $past(base_idx))
    else $error("shift result not written to target");

  zero_mask_a: assert property ( // RULE_04
    ce && issue_ready && issue_valid && is_shift &&
    index_gpr[srbs_pkg::SHIFT_ZERO_BIT] |=> gpr_data == 32'h0000_0000)
    else $error("shift with bit 26 set gave nonzero");

  shift_value_a: assert property ( // RULE_03
    !index_gpr[srbs_pkg::SHIFT_ZERO_BIT] |->
      shift_res == (source_gpr >> shift_n))
    else $error("shift right value wrong");

  record_update_a: assert property ( // RULE_06
    ce && issue_ready && issue_valid && is_shift |=>
      cr0_we == $past(record_flag))
    else $error("condition write does not follow record flag");

  record_value_a: assert property ( // RULE_15
    cr0_we && $past(ce) |-> condition_field_zero[0] == $past(so_in) &&
      condition_field_zero[3] == gpr_data[31] &&
      condition_field_zero[2] ==
        (!gpr_data[31] && gpr_data != 32'h0000_0000) &&
      condition_field_zero[1] == (gpr_data == 32'h0000_0000))
    else $error("condition value wrong");

  store_request_a: assert property ( // RULE_08
    ce && issue_ready && issue_valid && (is_stb || is_stbu || is_stbux) |=>
      mem_valid && mem_data == $past(source_gpr[7:0]) &&
      mem_addr == $past(eff_addr))
    else $error("byte request not issued");

  store_no_cr_a: assert property ( // RULE_10
    mem_valid || $past(mem_valid) |-> !cr0_we)
    else $error("byte store touched condition field");

  request_hold_a: assert property ( // RULE_16
    ce && mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) &&
      $stable(mem_data))
    else $error("byte request dropped before accept");

  update_guard_a: assert property ( // RULE_12
    ce && mem_valid && mem_ready && mem_fault |=> !gpr_we)
    else $error("base updated after fault");

  base_zero_a: assert property ( // RULE_09
    is_stb && base_idx == 5'h00 |-> eff_addr == offset_ext)
    else $error("base zero address wrong");

  indexed_addr_a: assert property ( // RULE_14
    is_stbux && base_idx == 5'h00 |-> eff_addr == index_gpr)
    else $error("indexed base zero address wrong");

  // completion, base update and decode corner checks
  store_done_a: assert property ( // RULE_16
    ce && mem_valid && mem_ready |=> !mem_valid && op_done && issue_ready)
    else $error("accepted store did not complete");

  update_write_a: assert property ( // RULE_12
    ce && mem_valid && mem_ready && !mem_fault && r.upd |=>
      gpr_we && gpr_data == $past(mem_addr) &&
      gpr_idx == $past(r.upd_idx))
    else $error("base update missing or wrong");

  base_offset_a: assert property ( // RULE_09
    is_stbu && base_idx != 5'h00 |->
      eff_addr == base_gpr_val + {{16{issue_instr[15]}}, issue_instr[15:0]})
    else $error("base plus offset address wrong");

  shift_zero_count_a: assert property ( // RULE_02
    ce && issue_ready && issue_valid && is_shift &&
    index_gpr[5:0] == 6'h00 |=> gpr_data == $past(source_gpr))
    else $error("shift by zero changed the word");

  illegal_flag_a: assert property ( // RULE_13
    ce && issue_ready && issue_valid &&
    !(is_shift || is_stb || is_stbu || is_stbux) |=>
      op_illegal && !gpr_we && !mem_valid)
    else $error("unknown opcode not flagged");

endmodule : srbs_slice

// ==== shared/srbs_pkg.sv ====
// srbs_pkg: opcodes, field positions and state types for the shift-right
// word and byte-store execution slice.
// assumes instruction bit 0 is the most significant bit of the word.
package srbs_pkg;

  // ---------------------------------------------------------------
  // opcode values
  // ---------------------------------------------------------------
  localparam logic [5:0] OP_EXTENDED     = 6'h1F;   // primary 31
  localparam logic [5:0] OP_STORE_BYTE   = 6'h26;   // primary 38
  localparam logic [5:0] OP_STORE_BYTE_U = 6'h27;   // primary 39
  localparam logic [9:0] XO_SHIFT_RIGHT  = 10'h218; // extended 536
  localparam logic [9:0] XO_STORE_BYTE_UX = 10'h0F7; // extended 247

  // ---------------------------------------------------------------
  // instruction field positions (lsb of each field, little-endian)
  // ---------------------------------------------------------------
  localparam int PRIMARY_LSB   = 26; // bits 0-5
  localparam int SOURCE_LSB    = 21; // bits 6-10
  localparam int BASE_LSB      = 16; // bits 11-15
  localparam int INDEX_LSB     = 11; // bits 16-20
  localparam int EXTENDED_LSB  = 1;  // bits 21-30
  localparam int RECORD_BIT    = 0;  // bit 31
  localparam int OFFSET_LSB    = 0;  // bits 16-31
  localparam int OFFSET_W      = 16;

  // ---------------------------------------------------------------
  // operand field positions
  // ---------------------------------------------------------------
  localparam int SHIFT_ZERO_BIT = 5; // bit 26 of index register
  localparam int SHIFT_CNT_LSB  = 0; // bits 27-31 of index register
  localparam int SHIFT_CNT_W    = 5;
  localparam int STORE_BYTE_LSB = 0; // bits 24-31 of source register
  localparam int WORD_W         = 32;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [3:0]  CR_RST    = 4'h0;
  localparam logic [4:0]  GPR_ZERO  = 5'h00;
  localparam logic [7:0]  BYTE_RST  = 8'h00;

  // slice sequencing
  typedef enum logic [0:0] {
    SRBS_IDLE,
    SRBS_STORE
  } srbs_state_t;

endpackage : srbs_pkg

// ==== testbench/srbs_mem_model.sv ====
// srbs_mem_model: data memory port taking byte store requests.
// assumes one request at a time, held by the slice until mem_ready.
`timescale 1ns/1ns
module srbs_mem_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        mem_valid,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  input  wire logic [3:0]  dly,
  input  wire logic        flt,
  output logic             mem_ready,
  output logic             mem_fault,
  output logic [31:0]      got_addr,
  output logic [7:0]       got_data
);
  logic [3:0] wait_cnt;
  // -------------------------------------------------------------
  // accept after dly cycles; fault line toggles while not sampled
  // -------------------------------------------------------------
  initial begin
    mem_ready = 1'b0;
    mem_fault = 1'b0;
    got_addr = 32'h0000_0000;
    got_data = 8'h00;
    wait_cnt = 4'h0;
  end
  always @(posedge clk) begin
    #1;
    if (sys_rst || !mem_valid || mem_ready) begin
      mem_ready = 1'b0;
      mem_fault = ~mem_fault;
      wait_cnt = 4'h0;
    end else if (wait_cnt >= dly) begin
      mem_ready = 1'b1;
      mem_fault = flt;
      got_addr = mem_addr;
      got_data = mem_data;
    end else begin
      wait_cnt = wait_cnt + 4'h1;
      mem_fault = ~mem_fault;
    end
  end
endmodule : srbs_mem_model

// ==== testbench/test_srbs_slice.sv ====
// test_srbs_slice: directed scenarios for shift-right word and stores.
// assumes the slice, its package and the memory model are compiled first.
`timescale 1ns/1ns
module test_srbs_slice;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ce = 1'b1;
  logic        issue_valid = 1'b0;
  logic [31:0] issue_instr = 32'h0000_0000;
  logic [31:0] source_gpr = 32'h0000_0000;
  logic [31:0] base_gpr_val = 32'h0000_0000;
  logic [31:0] index_gpr = 32'h0000_0000;
  logic        so_in = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic        flt = 1'b0;
  logic        mem_ready, mem_fault, issue_ready, gpr_we, cr0_we;
  logic        mem_valid, op_done, op_illegal;
  logic [4:0]  gpr_idx;
  logic [31:0] gpr_data, mem_addr, got_addr;
  logic [7:0]  mem_data, got_data;
  logic [3:0]  condition_field_zero;
  int          n_fail = 0;
  int          checks = 0;
  // -------------------------------------------------------------
  // clock and instances
  // -------------------------------------------------------------
  always #5 clk = ~clk;
  srbs_slice srbs_slice_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .issue_valid(issue_valid), .issue_instr(issue_instr),
    .source_gpr(source_gpr), .base_gpr_val(base_gpr_val),
    .index_gpr(index_gpr), .so_in(so_in), .mem_ready(mem_ready),
    .mem_fault(mem_fault), .issue_ready(issue_ready), .gpr_we(gpr_we),
    .gpr_idx(gpr_idx), .gpr_data(gpr_data), .cr0_we(cr0_we),
    .condition_field_zero(condition_field_zero), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_data(mem_data), .op_done(op_done),
    .op_illegal(op_illegal));
  srbs_mem_model srbs_mem_model_inst (.clk(clk), .sys_rst(sys_rst),
    .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
    .dly(dly), .flt(flt), .mem_ready(mem_ready), .mem_fault(mem_fault),
    .got_addr(got_addr), .got_data(got_data));
  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic summarize();
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  // offer one instruction and hold it until taken
  task automatic issue(input logic [31:0] ins, s, b, x, input logic so);
    issue_instr = ins;
    source_gpr = s;
    base_gpr_val = b;
    index_gpr = x;
    so_in = so;
    issue_valid = 1'b1;
    while (issue_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    issue_valid = 1'b0;
  endtask : issue
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic shift_case(input logic [31:0] rs, rb, input logic rc, so);
    logic [31:0] res;
    // rotate by 32-N under an N-zero mask is a plain logical shift by N
    res = rb[5] ? 32'h0000_0000 : rs >> rb[4:0];
    issue({srbs_pkg::OP_EXTENDED, 5'h04, 5'h06, 5'h05,
      srbs_pkg::XO_SHIFT_RIGHT, rc}, rs, 32'hA5A5_A5A5, rb, so);
    chk("gpr_we", 1, gpr_we);
    chk("gpr_idx", 6, gpr_idx);
    chk("gpr_data", res, gpr_data);
    chk("cr0_we", rc, cr0_we);
    if (rc) chk("cr0", {$signed(res) < 0, $signed(res) > 0, res == 0, so},
      condition_field_zero);
    chk("op_done", 1, op_done);
    @(posedge clk);
    #1;
    chk("gpr_we_end", 0, gpr_we);
  endtask : shift_case
  task automatic store_case(input int op, input logic [4:0] ra,
    input logic [31:0] base, imm, input logic f, input logic [3:0] d);
    logic [31:0] ea, ins, src;
    logic        upd, we_seen, cr_seen;
    ea = (ra == 0 ? 32'h0 : base) +
      (op == 2 ? imm : {{16{imm[15]}}, imm[15:0]});
    upd = op != 0 && ra != 0 && !f;
    src = 32'h1234_56A5 ^ imm;
    ins = op == 2 ? {srbs_pkg::OP_EXTENDED, 5'h06, ra, 5'h07,
      srbs_pkg::XO_STORE_BYTE_UX, 1'b0} : {op == 1 ?
      srbs_pkg::OP_STORE_BYTE_U : srbs_pkg::OP_STORE_BYTE, 5'h06, ra,
      imm[15:0]};
    dly = d;
    flt = f;
    we_seen = 1'b0;
    cr_seen = 1'b0;
    issue(ins, src, base, op == 2 ? imm : ~imm, 1'b1);
    chk("mem_valid", 1, mem_valid);
    chk("mem_addr", ea, mem_addr);
    chk("mem_data", src[7:0], mem_data);
    if (d > 0) chk("issue_ready", 0, issue_ready);
    for (int i = 0; i < 40 && op_done !== 1'b1; i++) begin
      we_seen = we_seen | (gpr_we !== 1'b0);
      cr_seen = cr_seen | (cr0_we !== 1'b0);
      @(posedge clk);
      #1;
    end
    chk("op_done", 1, op_done);
    chk("early_we", 0, we_seen);
    chk("cr0_we", 0, cr_seen | cr0_we);
    chk("gpr_we", upd, gpr_we);
    if (upd) chk("gpr_data", ea, gpr_data);
    if (upd) chk("gpr_idx", ra, gpr_idx);
    chk("got_addr", ea, got_addr);
    chk("got_data", src[7:0], got_data);
    chk("mem_valid_end", 0, mem_valid);
  endtask : store_case
  task automatic illegal_case();
    issue({srbs_pkg::OP_EXTENDED, 5'h06, 5'h04, 5'h05, 10'h0D7, 1'b0},
      32'h0000_0001, 32'h0000_0002, 32'h0000_0003, 1'b0);
    chk("op_illegal", 1, op_illegal);
    chk("gpr_we", 0, gpr_we);
    chk("mem_valid", 0, mem_valid);
  endtask : illegal_case
  // frozen while ce low: no take, pulses hold
  task automatic ce_case();
    ce = 1'b0;
    issue_instr = {srbs_pkg::OP_EXTENDED, 5'h04, 5'h06, 5'h05,
      srbs_pkg::XO_SHIFT_RIGHT, 1'b0};
    source_gpr = 32'h0000_0F00;
    index_gpr = 32'h0000_0004;
    issue_valid = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("gpr_we_frozen", 0, gpr_we);
    ce = 1'b1;
    @(posedge clk);
    #1;
    ce = 1'b0;
    issue_valid = 1'b0;
    chk("gpr_data_ce", 32'h0000_00F0, gpr_data);
    repeat (2) @(posedge clk);
    #1;
    chk("gpr_we_held", 1, gpr_we);
    ce = 1'b1;
    @(posedge clk);
    #1;
    chk("gpr_we_after", 0, gpr_we);
  endtask : ce_case
  // reset in mid-store, with ce low, clears the pending request
  task automatic rst_case();
    dly = 4'hF;
    issue({srbs_pkg::OP_STORE_BYTE, 5'h06, 5'h00, 16'h0040},
      32'h0000_0033, 32'h0000_0000, 32'h0000_0000, 1'b0);
    chk("mem_addr_pend", 32'h0000_0040, mem_addr);
    ce = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("mem_valid_rst2", 0, mem_valid);
    chk("ready_rst2", 1, issue_ready);
    sys_rst = 1'b0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("op_done_rst2", 0, op_done);
    chk("mem_valid_idle", 0, mem_valid);
  endtask : rst_case
  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk("ready_rst", 1, issue_ready);
    chk("mem_valid_rst", 0, mem_valid);
    shift_case(32'h9000_3000, 32'h0000_0024, 1'b0, 1'b0);
    shift_case(32'hB004_3001, 32'h0000_0004, 1'b1, 1'b0);
    shift_case(32'h8765_4321, 32'h0000_0000, 1'b1, 1'b1);
    shift_case(32'hFFFF_FFFF, 32'hFFFF_FFDF, 1'b1, 1'b0);
    shift_case(32'h0000_0001, 32'h0000_0001, 1'b1, 1'b1);
    ce_case();
    store_case(0, 5'h00, 32'h5555_0000, 32'h0000_FFFC, 1'b0, 0);
    store_case(0, 5'h03, 32'h0000_1000, 32'h0000_8000, 1'b0, 2);
    store_case(1, 5'h04, 32'h0000_2000, 32'h0000_0010, 1'b0, 3);
    store_case(1, 5'h04, 32'h0000_2001, 32'h0000_0011, 1'b1, 1);
    store_case(1, 5'h00, 32'h0000_3000, 32'h0000_0020, 1'b0, 0);
    store_case(2, 5'h04, 32'h0000_0100, 32'h0000_0024, 1'b0, 0);
    store_case(2, 5'h00, 32'h7777_0000, 32'h0000_0500, 1'b0, 2);
    rst_case();
    illegal_case();
    summarize();
  end
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
endmodule : test_srbs_slice
